/* tb/tb_top.sv */
// Top testbench for the timer/counter
`timescale 1ns/1ps
module tb_top
   import tmr_pkg::*;
;
   logic mclk = 0, rst_b = 1, instr_cycle = 0, sleep = 0, wdt_tick = 0, go = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [3:0] wb_adr_i = '0, wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = '0, wb_dat_o, r;
   logic wb_ack_o, irq, wdt_tick_out, external_count_pin;
   int n_mismatch = 0, n_tests = 0, b, k;
   tmr_counter #(.PRE_WIDTH(8)) u_tmr_counter (.mclk, .rst_b, .ce(1'b1), .instr_cycle,
      .external_count_pin, .sleep, .wdt_tick, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .wdt_tick_out);
   tmr_pin_model u_tmr_pin_model (.mclk, .go, .pin(external_count_pin));
   initial forever #2 mclk = ~mclk;
   always @(posedge mclk) wdt_tick <= ($urandom % 4) == 0;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h00_0000, d};
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 8'h00);
      chk(r, e);
   endtask
   task automatic ic(input int n);
      repeat (n) begin
         @(posedge mclk) instr_cycle <= 1'b1;
         @(posedge mclk) instr_cycle <= 1'b0;
      end
      repeat (2) @(posedge mclk);
   endtask
   task automatic stop_test;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      // Reset asserted as an event so the asynchronous reset branches run at time zero
      rst_b <= 1'b0;
      void'($urandom(46917));
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      rd(ADDR_COUNT, 32'h0000_0000);
      rd(ADDR_OPTION, 32'h0000_00ff);
      rd(ADDR_STATUS, 32'h0000_0001);
      rd(4'h6, 32'h0000_0000);
      $display("test reset done");
      wb(1'b1, ADDR_OPTION, 8'h08);
      b = $urandom % 200;
      k = 1 + $urandom % 8;
      wb(1'b1, ADDR_COUNT, b[7:0]);
      ic(k + 2);
      rd(ADDR_COUNT, b + k);
      wb(1'b1, ADDR_INTCTL, 8'h20);
      wb(1'b1, ADDR_COUNT, 8'hfe);
      ic(4);
      rd(ADDR_INTCTL, 32'h0000_0024);
      chk(32'(irq), 32'h0000_0001);
      wb(1'b1, ADDR_INTCTL, 8'h00);
      @(posedge mclk);
      chk(32'(irq), 32'h0000_0000);
      rd(ADDR_INTCTL, 32'h0000_0004);
      wb(1'b1, ADDR_INTCTL, 8'h24);
      rd(ADDR_INTCTL, 32'h0000_0020);
      $display("test timer and overflow done");
      sleep <= 1'b1;
      ic(3);
      rd(ADDR_COUNT, 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0003);
      sleep <= 1'b0;
      $display("test sleep done");
      for (int e = 0; e < 2; e++) begin
         wb(1'b1, ADDR_OPTION, 8'h28 | 8'(e << 4));
         wb(1'b0, ADDR_COUNT, 8'h00);
         b = r[7:0];
         go <= 1'b1;
         @(posedge mclk) go <= 1'b0;
         repeat (3) @(posedge mclk);
         rd(ADDR_COUNT, b + (e == 0));
         repeat (12) @(posedge mclk);
         rd(ADDR_COUNT, b + 1);
      end
      $display("test counter done");
      for (int p = 0; p < 3; p++) begin
         wb(1'b1, ADDR_OPTION, 8'h08);
         wb(1'b1, ADDR_OPTION, 8'(p));
         rd(ADDR_STATUS, 32'h0000_0000);
         @(posedge mclk) k = wdt_tick;
         @(posedge mclk) chk(32'(wdt_tick_out), 32'(k));
         wb(1'b0, ADDR_COUNT, 8'h00);
         b = r[7:0];
         ic(4 << p);
         rd(ADDR_COUNT, b + 2);
      end
      $display("test prescaler done");
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      stop_test();
   end
endmodule // tb_top
bind tmr_counter tmr_checker #(.PRE_WIDTH(PRE_WIDTH)) u_tmr_checker (.mclk, .rst_b, .ce, .instr_cycle,
   .external_count_pin, .sleep, .wdt_tick, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .wdt_tick_out);

/* tb/tmr_checker.sv */
// Port assertions for the timer/counter
`timescale 1ns/1ps
module tmr_checker
   import tmr_pkg::*;
#(parameter int PRE_WIDTH = 8) (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        ce,
   input wire logic        instr_cycle,
   input wire logic        external_count_pin,
   input wire logic        sleep,
   input wire logic        wdt_tick,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq,
   input wire logic        wdt_tick_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic tk;
   assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_latency: assert property (tk |=> wb_ack_o) else $error("ack missing");
   a_ack_cause: assert property (!tk |=> !wb_ack_o) else $error("ack unasked");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper bits set");
   a_unmapped_zero: assert property (tk && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read");
   a_status_sleep: assert property (tk && !wb_we_i && wb_adr_i == ADDR_STATUS && $stable(sleep)
      |=> wb_dat_o[STS_SLEEP] == $past(sleep)) else $error("sleep bit");
   a_mask_irq: assert property (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_INTCTL
      && !wb_dat_i[INT_EN] |=> ##1 !irq) else $error("masked irq");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_b |-> !wb_ack_o && !irq)
      else $error("output in reset");
endmodule // tmr_checker

/* tb/tmr_pin_model.sv */
// External count source: one high pulse per request
`timescale 1ns/1ps
module tmr_pin_model #(parameter int HI = 8) (
   input wire logic mclk,
   input wire logic go,
   output logic     pin
);
   int n = 0;
   always @(posedge mclk) n <= go ? HI : (n > 0 ? n - 1 : 0);
   assign pin = n > 0;
endmodule // tmr_pin_model

/* verilog/tmr_counter.sv */
// 8-bit timer/counter with shared prescaler, overflow interrupt and Wishbone registers
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module tmr_counter
   import tmr_pkg::*;
#(
   parameter int PRE_WIDTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   input  wire logic             instr_cycle,
   input  wire logic             external_count_pin,
   input  wire logic             sleep,
   input  wire logic             wdt_tick,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [3:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  irq,
   output logic                  wdt_tick_out
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]  count_register_q;
   logic [7:0]  count_register_d;
   logic [7:0]  option_q;
   logic [7:0]  option_d;
   logic        overflow_flag_q;
   logic        overflow_flag_d;
   logic        overflow_irq_enable_q;
   logic        overflow_irq_enable_d;
   logic [1:0]  inhibit_q;
   logic [1:0]  inhibit_d;
   logic        pin_q;
   logic        psa_q;
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        irq_q;
   logic        irq_d;
   logic        wdt_out_q;

   cfg_s        cfg;
   logic        wr_stb;
   logic        rd_stb;
   logic        ext_edge;
   logic        src_tick;
   logic        pre_in;
   logic        pre_out;
   logic        pre_clr;
   logic        tmr_tick;
   logic        overflow;

   assign cfg.clk_src   = option_q[OPT_CS];
   assign cfg.edge_fall = option_q[OPT_EDGE];
   assign cfg.psa_wdt   = option_q[OPT_PSA];
   assign cfg.ps_rate   = option_q[OPT_PS_LSB +: OPT_PS_W];

   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
   assign rd_stb = wb_cyc_i & wb_stb_i & ~ack_q;

   ////////////////////////////////////////////////////////////////////////////
   // Count source
   always_comb begin
      ext_edge = cfg.edge_fall ? (pin_q & ~external_count_pin) : (~pin_q & external_count_pin);
      src_tick = ~sleep & (cfg.clk_src ? ext_edge : instr_cycle);
      // prescaler input from one user only
      pre_in   = cfg.psa_wdt ? wdt_tick : src_tick;
      pre_clr  = (psa_q != cfg.psa_wdt);
   end

   // no bus path to prescaler count
   tmr_prescaler #(
      .WIDTH (PRE_WIDTH)
   ) u_pre (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .ce       (ce),
      .clr      (pre_clr),
      .tick_in  (pre_in),
      .rate     (cfg.ps_rate),
      .tick_out (pre_out)
   );

   always_comb begin
      tmr_tick = cfg.psa_wdt ? src_tick : pre_out;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter and flags
   always_comb begin
      count_register_d      = count_register_q;
      inhibit_d             = inhibit_q;
      overflow              = 1'b0;
      option_d              = option_q;
      overflow_irq_enable_d = overflow_irq_enable_q;
      overflow_flag_d       = overflow_flag_q;
      if (wr_stb && wb_adr_i == ADDR_COUNT) begin
         count_register_d = wb_dat_i[7:0];
         inhibit_d        = WR_INHIBIT;
      end else begin
         if (inhibit_q != 2'h0 && instr_cycle && !sleep) begin
            inhibit_d = inhibit_q - 2'h1;
         end
         if (tmr_tick && inhibit_q == 2'h0) begin
            count_register_d = count_register_q + 8'h01;
            overflow         = (count_register_q == 8'hFF);
         end
      end
      if (wr_stb && wb_adr_i == ADDR_OPTION) begin
         option_d = wb_dat_i[7:0];
      end
      if (wr_stb && wb_adr_i == ADDR_INTCTL) begin
         overflow_irq_enable_d = wb_dat_i[INT_EN];
         if (wb_dat_i[INT_FLAG]) begin
            overflow_flag_d = 1'b0;
         end
      end
      if (overflow) begin
         overflow_flag_d = 1'b1;
      end
      irq_d = overflow_flag_d & overflow_irq_enable_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer
   always_comb begin
      ack_d   = rd_stb;
      rdata_d = 32'h0000_0000;
      if (rd_stb && !wb_we_i) begin
         if (wb_adr_i == ADDR_COUNT) begin
            rdata_d[7:0] = count_register_q;
         end else if (wb_adr_i == ADDR_OPTION) begin
            rdata_d[7:0] = option_q;
         end else if (wb_adr_i == ADDR_INTCTL) begin
            rdata_d[INT_FLAG] = overflow_flag_q;
            rdata_d[INT_EN]   = overflow_irq_enable_q;
         end else if (wb_adr_i == ADDR_STATUS) begin
            rdata_d[STS_WDT_OWNS] = cfg.psa_wdt;
            rdata_d[STS_SLEEP]    = sleep;
         end else begin
            rdata_d = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_register_q      <= COUNT_RST;
         option_q              <= OPTION_RST;
         overflow_flag_q       <= 1'b0;
         overflow_irq_enable_q <= 1'b0;
         inhibit_q             <= 2'h0;
         pin_q                 <= 1'b0;
         psa_q                 <= 1'b1;
         ack_q                 <= 1'b0;
         rdata_q               <= 32'h0000_0000;
         irq_q                 <= 1'b0;
         wdt_out_q             <= 1'b0;
      end else if (ce) begin
         count_register_q      <= count_register_d;
         option_q              <= option_d;
         overflow_flag_q       <= overflow_flag_d;
         overflow_irq_enable_q <= overflow_irq_enable_d;
         inhibit_q             <= inhibit_d;
         pin_q                 <= external_count_pin;
         psa_q                 <= cfg.psa_wdt;
         ack_q                 <= ack_d;
         rdata_q               <= rdata_d;
         irq_q                 <= irq_d;
         // watchdog sees prescaled ticks only when it owns the prescaler
         wdt_out_q             <= cfg.psa_wdt ? pre_out : wdt_tick;
      end
   end

   assign wb_ack_o     = ack_q;
   assign wb_dat_o     = rdata_q;
   assign irq          = irq_q;
   assign wdt_tick_out = wdt_out_q;
endmodule // tmr_counter

/* verilog/tmr_pkg.sv */
// Package: register map, field positions, reset values and carriers of the 8-bit timer/counter
package tmr_pkg;

   // Word byte addresses on the register bus
   localparam logic [3:0] ADDR_COUNT   = 4'h0;
   localparam logic [3:0] ADDR_OPTION  = 4'h4;
   localparam logic [3:0] ADDR_INTCTL  = 4'h8;
   localparam logic [3:0] ADDR_STATUS  = 4'hC;

   // Option configuration register fields
   localparam int OPT_PS_LSB   = 0;
   localparam int OPT_PS_W     = 3;
   localparam int OPT_PSA      = 3;
   localparam int OPT_EDGE     = 4;
   localparam int OPT_CS       = 5;
   localparam logic [7:0] OPTION_RST = 8'hFF;

   // Interrupt control register fields (flag sticky, write one to clear)
   localparam int INT_FLAG     = 2;
   localparam int INT_EN       = 5;
   localparam logic [7:0] INTCTL_RST = 8'h00;

   // Status register fields
   localparam int STS_WDT_OWNS = 0;
   localparam int STS_SLEEP    = 1;

   localparam logic [7:0] COUNT_RST    = 8'h00;
   localparam logic [1:0] WR_INHIBIT   = 2'h2;
   localparam logic [7:0] PRE_RST      = 8'h00;

   typedef struct packed {
      logic       clk_src;
      logic       edge_fall;
      logic       psa_wdt;
      logic [2:0] ps_rate;
   } cfg_s;

endpackage

/* verilog/tmr_prescaler.sv */
// Shared 8-bit prescaler, not visible to software
`timescale 1ns/1ps
module tmr_prescaler
   import tmr_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   input  wire logic             clr,
   input  wire logic             tick_in,
   input  wire logic [2:0]       rate,
   output logic                  tick_out
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;
   logic [WIDTH-1:0] cnt_inc;

   always_comb begin
      cnt_inc  = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      cnt_d    = cnt_q;
      tick_out = 1'b0;
      if (clr) begin
         cnt_d = '0;
      end else if (tick_in) begin
         cnt_d    = cnt_inc;
         // Ratio 2^(rate+1): carry out of the selected bit
         tick_out = cnt_q[rate] & ~cnt_inc[rate];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (ce) begin
         cnt_q <= cnt_d;
      end
   end
endmodule // tmr_prescaler
